// ### rtl/ppg_pkg.sv
// Shared constants and types for the programmable pulse generator
`default_nettype none
package ppg_pkg;
  // Register byte addresses
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_PERIOD = 5'h04;
  localparam logic [4:0] ADDR_DELAY = 5'h08;
  localparam logic [4:0] ADDR_WIDTH = 5'h0C;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  // Register select codes
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_PERIOD = 3'h1;
  localparam logic [2:0] SEL_DELAY = 3'h2;
  localparam logic [2:0] SEL_WIDTH = 3'h3;
  localparam logic [2:0] SEL_STATUS = 3'h4;
  localparam logic [2:0] SEL_NONE = 3'h7;
  // Operating modes
  typedef enum logic [1:0] {MODE_CONT, MODE_GATED, MODE_EXT, MODE_MAN} ppg_mode_t;
  // Control register layout
  typedef struct packed {
    logic [27:0] rsvd;
    logic comp;
    logic pair_mode_select;
    ppg_mode_t mode;
  } ppg_ctrl_t;
  // Period, delay and width setting layout: decade range and fine count
  typedef struct packed {
    logic [12:0] rsvd;
    logic [2:0] range;
    logic [15:0] fine;
  } ppg_time_t;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PERIOD_RST = 32'h0001_0002;
  localparam logic [31:0] DELAY_RST = 32'h0000_0000;
  localparam logic [31:0] WIDTH_RST = 32'h0006_0000;
  // Range codes
  localparam logic [2:0] PER_RNG_MAX = 3'h6;
  localparam logic [2:0] WID_RNG_MAX = 3'h5;
  localparam logic [2:0] RNG_SQUARE = 3'h6;
  localparam logic [2:0] RNG_CUSTOM = 3'h7;
  // Status register bits
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_GATE_BIT = 1;
  localparam int STAT_PULSE_BIT = 2;
  localparam int STAT_SYNC_BIT = 3;
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SHORT_PERIOD_NS = 200;
  localparam int SHORT_PER_CYC = (SHORT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_PER_CYC = 2;
  // Duty limits as fractions of 256
  localparam logic [7:0] LIM70_NUM = 8'hB3;
  localparam logic [7:0] LIM30_NUM = 8'h4D;
  localparam int LIM_SHIFT = 8;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### rtl/ppg_top.sv
// Programmable pulse generator timing core with AXI4-Lite registers
// Overview of operation
// [R01] Continuous mode repeats pulses endlessly at the selected period.
// [R02] Triggered mode idles until trigger or button, then one pulse or pair.
// [R03] Gated mode runs while the gate input is high, idles while low.
// [R04] Gated mode starts its first period on the gate rising edge.
// [R05] Pair mode produces two pulses per period in run modes.
// [R06] Pair mode places the second pulse's leading edge at the delay setting.
// [R07] Pairs appear on main and logic outputs; sync keeps one cycle per period.
// [R08] External-width mode takes width and period from the trigger input.
// [R09] Complement swaps active and quiescent levels of pulse outputs.
// [R10] Complement never touches the sync output.
// [R11] Period uses seven decade ranges with fine adjustment in each.
// [R12] Width uses six decade ranges.
// [R13] Width capped at 70% of period, 50% at the shortest periods.
// [R14] Width has a square position and a custom-range position.
// [R15] Sync is a half-period square, following the trigger in trigger modes.
// [R16] Delay moves the main pulse after sync, plus fixed latency.
// [R17] Delay capped at 70% of period, 30% at the shortest periods.
// [R18] Triggering and gate opening happen on the input rising edge.
// [R19] Four outputs driven together: sync, true, inverted and main.
// [R20] Inverted logic output mirrors the true output with levels swapped.
// [R21] External fire position holds outputs inactive until a trigger.
// [R22] Manual fire position starts one sequence per button press.
// [R23] Period, delay and width are loadable cycle counts of one clock.
// [R24] Source holds the input low between pulses so each edge counts once.
`default_nettype none
module ppg_top #(
  parameter int CNT_W = 36,
  parameter int CUSTOM_RNG = 2
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // AXI4-Lite write address and data
  input wire logic [4:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [4:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Front panel inputs
  input wire logic FIRE_GATE_IN,
  input wire logic MANUAL_FIRE_BUTTON,
  // Pulse outputs
  output logic SYNC_OUT,
  output logic LOGIC_OUT,
  output logic LOGIC_OUT_N,
  output logic MAIN_OUT
);

  generate
    if (CNT_W < 36)
      $error("CNT_W must be at least 36 to hold the longest setting");
    if (CUSTOM_RNG < 0 || CUSTOM_RNG > 6)
      $error("CUSTOM_RNG must lie in 0..6");
  endgenerate

  typedef enum logic {ST_IDLE, ST_RUN} ppg_state_t;

  // Address decode shared by read and write paths
  function automatic logic [2:0] reg_sel(input logic [4:0] a);
    if (a == ppg_pkg::ADDR_CTRL)
      reg_sel = ppg_pkg::SEL_CTRL;
    else if (a == ppg_pkg::ADDR_PERIOD)
      reg_sel = ppg_pkg::SEL_PERIOD;
    else if (a == ppg_pkg::ADDR_DELAY)
      reg_sel = ppg_pkg::SEL_DELAY;
    else if (a == ppg_pkg::ADDR_WIDTH)
      reg_sel = ppg_pkg::SEL_WIDTH;
    else if (a == ppg_pkg::ADDR_STATUS)
      reg_sel = ppg_pkg::SEL_STATUS;
    else
      reg_sel = ppg_pkg::SEL_NONE;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        merge[i*8 +: 8] = d[i*8 +: 8];
  endfunction

  // Cycles per step of each decade range
  function automatic logic [19:0] decade(input logic [2:0] r);
    case (r)
      3'h0: decade = 20'h00001;
      3'h1: decade = 20'h0000A;
      3'h2: decade = 20'h00064;
      3'h3: decade = 20'h003E8;
      3'h4: decade = 20'h02710;
      3'h5: decade = 20'h186A0;
      default: decade = 20'hF4240;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] to_cyc(input logic [15:0] f, input logic [2:0] r);
    logic [35:0] p;
    p = {20'h00000, f} * {16'h0000, decade(r)};
    to_cyc = CNT_W'(p);
  endfunction

  function automatic logic [CNT_W-1:0] frac(input logic [CNT_W-1:0] v, input logic [7:0] n);
    logic [CNT_W+7:0] p;
    p = {8'h00, v} * {{CNT_W{1'b0}}, n};
    frac = p[CNT_W+7:ppg_pkg::LIM_SHIFT];
  endfunction

  // Registers
  ppg_pkg::ppg_ctrl_t ctrl_reg;
  ppg_pkg::ppg_time_t period_reg;
  ppg_pkg::ppg_time_t delay_reg;
  ppg_pkg::ppg_time_t width_reg;

  // Bus state
  logic aw_held_reg;
  logic w_held_reg;
  logic [4:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Input synchronisers and edge history
  logic gate_meta_reg;
  logic gate_sync_reg;
  logic gate_prev_reg;
  logic btn_meta_reg;
  logic btn_sync_reg;
  logic btn_prev_reg;

  // Core state
  ppg_state_t state_reg;
  ppg_state_t state_next;
  logic [CNT_W-1:0] phase_reg;
  logic [CNT_W-1:0] phase_next;
  logic sync_reg;
  logic pulse_reg;
  logic pulse_n_reg;

  // Bus handshakes
  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  wire [2:0] wsel = reg_sel(awaddr_reg);
  wire [2:0] rsel = reg_sel(S_AXI_ARADDR);
  wire ar_fire = S_AXI_ARVALID && !rvalid_reg;
  assign S_AXI_AWREADY = !aw_held_reg;
  assign S_AXI_WREADY = !w_held_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  // Settings converted to cycle counts
  wire [2:0] per_rng = (period_reg.range > ppg_pkg::PER_RNG_MAX) ? ppg_pkg::PER_RNG_MAX :
                       period_reg.range; // [R11]
  wire [2:0] cust_rng = 3'(CUSTOM_RNG);
  wire [2:0] del_rng = (delay_reg.range == ppg_pkg::RNG_CUSTOM) ? cust_rng :
                       (delay_reg.range > ppg_pkg::WID_RNG_MAX) ? ppg_pkg::WID_RNG_MAX :
                       delay_reg.range;
  wire [2:0] wid_rng = (width_reg.range == ppg_pkg::RNG_CUSTOM) ? cust_rng :
                       width_reg.range; // [R12] [R14]
  wire square_sel = width_reg.range == ppg_pkg::RNG_SQUARE; // [R14]
  wire [CNT_W-1:0] per_raw = to_cyc(period_reg.fine, per_rng); // [R23]
  wire [CNT_W-1:0] per_cyc = (per_raw < CNT_W'(ppg_pkg::MIN_PER_CYC)) ?
                             CNT_W'(ppg_pkg::MIN_PER_CYC) : per_raw;
  wire [CNT_W-1:0] del_raw = to_cyc(delay_reg.fine, del_rng); // [R16]
  wire [CNT_W-1:0] wid_raw = to_cyc(width_reg.fine, wid_rng);
  wire [CNT_W-1:0] half_per = per_cyc >> 1;

  // Duty limits: shorter periods leave the width and delay paths less room
  wire short_per = per_cyc < CNT_W'(ppg_pkg::SHORT_PER_CYC);
  wire [CNT_W-1:0] lim70 = frac(per_cyc, ppg_pkg::LIM70_NUM);
  wire [CNT_W-1:0] lim30 = frac(per_cyc, ppg_pkg::LIM30_NUM);
  wire [CNT_W-1:0] wid_lim = short_per ? half_per : lim70; // [R13]
  wire [CNT_W-1:0] del_lim = short_per ? lim30 : lim70; // [R17]
  wire [CNT_W-1:0] wid_min = (wid_raw == '0) ? CNT_W'(1) : wid_raw;
  wire [CNT_W-1:0] wid_cyc = square_sel ? half_per :
                             (wid_min > wid_lim) ? wid_lim : wid_min; // [R13] [R14]
  wire [CNT_W-1:0] del_cyc = (del_raw > del_lim) ? del_lim : del_raw; // [R17]

  // Trigger sources
  wire gate_rise = gate_sync_reg && !gate_prev_reg; // [R18]
  wire btn_rise = btn_sync_reg && !btn_prev_reg; // [R22]
  ppg_pkg::ppg_mode_t mode;
  assign mode = ctrl_reg.mode;
  wire ext_width = (mode == ppg_pkg::MODE_EXT) && square_sel; // [R08]
  wire external_fire_position_mode = (mode == ppg_pkg::MODE_EXT) || (mode == ppg_pkg::MODE_MAN);
  wire external_fire_position_level = (mode == ppg_pkg::MODE_MAN) ? btn_sync_reg : gate_sync_reg;
  wire one_shot_start = ((mode == ppg_pkg::MODE_EXT) && !ext_width && gate_rise) ||
                        ((mode == ppg_pkg::MODE_MAN) && btn_rise); // [R02] [R21] [R22]
  wire wrap = phase_reg >= per_cyc - CNT_W'(1);

  // Core sequencer
  always_comb
  begin
    state_next = state_reg;
    phase_next = phase_reg + CNT_W'(1);
    case (state_reg)
      ST_IDLE:
      begin
        phase_next = '0;
        if (mode == ppg_pkg::MODE_CONT)
          state_next = ST_RUN; // [R01]
        else if (mode == ppg_pkg::MODE_GATED && gate_rise)
          state_next = ST_RUN; // [R04] [R18]
        else if (one_shot_start)
          state_next = ST_RUN; // [R02]
      end
      default:
      begin
        if (mode == ppg_pkg::MODE_GATED && !gate_sync_reg)
        begin
          state_next = ST_IDLE; // [R03]
          phase_next = '0;
        end
        else if (ext_width)
        begin
          state_next = ST_IDLE;
          phase_next = '0;
        end
        else if (wrap)
        begin
          phase_next = '0;
          if (external_fire_position_mode)
            state_next = ST_IDLE; // [R02]
        end
      end
    endcase
  end

  // Pulse windows inside the period
  wire running = state_reg == ST_RUN;
  wire after_del = phase_reg >= del_cyc;
  wire del_win = after_del && ((phase_reg - del_cyc) < wid_cyc); // [R16]
  wire first_win = ctrl_reg.pair_mode_select ? (phase_reg < wid_cyc) : del_win; // [R05]
  wire second_win = ctrl_reg.pair_mode_select && del_win; // [R06]
  wire pulse_raw = ext_width ? gate_sync_reg :
                   (running && (first_win || second_win)); // [R05] [R07] [R08]
  // Sync stays one square cycle per period regardless of pairing
  wire sync_raw = external_fire_position_mode ? external_fire_position_level :
                  (running && (phase_reg < half_per)); // [R07] [R15]
  wire pulse_out = pulse_raw ^ ctrl_reg.comp; // [R09]

  // Synchronisers for the front panel inputs
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      gate_meta_reg <= 1'b0;
      gate_sync_reg <= 1'b0;
      gate_prev_reg <= 1'b0;
      btn_meta_reg <= 1'b0;
      btn_sync_reg <= 1'b0;
      btn_prev_reg <= 1'b0;
    end
    else
    begin
      gate_meta_reg <= FIRE_GATE_IN;
      gate_sync_reg <= gate_meta_reg;
      gate_prev_reg <= gate_sync_reg;
      btn_meta_reg <= MANUAL_FIRE_BUTTON;
      btn_sync_reg <= btn_meta_reg;
      btn_prev_reg <= btn_sync_reg;
    end
  end

  // Sequencer and output flops
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      state_reg <= ST_IDLE;
      phase_reg <= '0;
      sync_reg <= 1'b0;
      pulse_reg <= 1'b0;
      pulse_n_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      sync_reg <= sync_raw; // [R10]
      pulse_reg <= pulse_out; // [R19]
      pulse_n_reg <= !pulse_out; // [R20]
    end
  end

  assign SYNC_OUT = sync_reg;
  assign LOGIC_OUT = pulse_reg;
  assign LOGIC_OUT_N = pulse_n_reg;
  assign MAIN_OUT = pulse_reg;

  // Write channel: address and data accepted in either order
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 5'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (S_AXI_AWVALID && !aw_held_reg)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR;
      end
      else if (do_write)
        aw_held_reg <= 1'b0;
      if (S_AXI_WVALID && !w_held_reg)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA;
        wstrb_reg <= S_AXI_WSTRB;
      end
      else if (do_write)
        w_held_reg <= 1'b0;
    end
  end

  // Register file and write response
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ctrl_reg <= ppg_pkg::CTRL_RST;
      period_reg <= ppg_pkg::PERIOD_RST;
      delay_reg <= ppg_pkg::DELAY_RST;
      width_reg <= ppg_pkg::WIDTH_RST;
      bvalid_reg <= 1'b0;
      bresp_reg <= ppg_pkg::RESP_OKAY;
    end
    else
    begin
      if (do_write)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (wsel == ppg_pkg::SEL_NONE) ? ppg_pkg::RESP_SLVERR :
                     ppg_pkg::RESP_OKAY;
        if (wsel == ppg_pkg::SEL_CTRL)
          ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_000F;
        if (wsel == ppg_pkg::SEL_PERIOD)
          period_reg <= merge(period_reg, wdata_reg, wstrb_reg) & 32'h0007_FFFF; // [R23]
        if (wsel == ppg_pkg::SEL_DELAY)
          delay_reg <= merge(delay_reg, wdata_reg, wstrb_reg) & 32'h0007_FFFF;
        if (wsel == ppg_pkg::SEL_WIDTH)
          width_reg <= merge(width_reg, wdata_reg, wstrb_reg) & 32'h0007_FFFF;
      end
      else if (bvalid_reg && S_AXI_BREADY)
        bvalid_reg <= 1'b0;
    end
  end

  // Read path
  logic [31:0] status_word;
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[ppg_pkg::STAT_RUN_BIT] = running;
    status_word[ppg_pkg::STAT_GATE_BIT] = gate_sync_reg;
    status_word[ppg_pkg::STAT_PULSE_BIT] = pulse_reg;
    status_word[ppg_pkg::STAT_SYNC_BIT] = sync_reg;
  end

  wire [31:0] rd_mux = (rsel == ppg_pkg::SEL_CTRL) ? ctrl_reg :
                       (rsel == ppg_pkg::SEL_PERIOD) ? period_reg :
                       (rsel == ppg_pkg::SEL_DELAY) ? delay_reg :
                       (rsel == ppg_pkg::SEL_WIDTH) ? width_reg :
                       (rsel == ppg_pkg::SEL_STATUS) ? status_word : 32'h0000_0000;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= ppg_pkg::RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= (rsel == ppg_pkg::SEL_NONE) ? ppg_pkg::RESP_SLVERR : ppg_pkg::RESP_OKAY;
    end
    else if (rvalid_reg && S_AXI_RREADY)
      rvalid_reg <= 1'b0;
  end

endmodule
`default_nettype wire

// ### testbench/ppg_asserts.sv
// Concurrent checks on the pulse generator bus and pulse outputs
`default_nettype none
module ppg_asserts (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Register bus
  input wire logic [4:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Panel input and outputs
  input wire logic FIRE_GATE_IN,
  input wire logic SYNC_OUT,
  input wire logic LOGIC_OUT,
  input wire logic LOGIC_OUT_N,
  input wire logic MAIN_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ctrl_reg;
  logic wr_taken;
  logic gated;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  assign wr_taken = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  assign gated = ctrl_reg[1:0] == ppg_pkg::MODE_GATED;
  // Shadow of the low control bits; only whole-word writes are expected
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      ctrl_reg <= 4'h0;
    else if (wr_taken && S_AXI_AWADDR == ppg_pkg::ADDR_CTRL)
      ctrl_reg <= S_AXI_WDATA[3:0];
  end
  sequence write_taken_s;
    wr_taken && !S_AXI_BVALID;
  endsequence
  sequence gate_shut_s;
    (gated && !FIRE_GATE_IN)[*5];
  endsequence
  inv_mirror_a: assert property (LOGIC_OUT_N == !LOGIC_OUT)
    else $error("inverted output differs");
  main_equal_a: assert property (MAIN_OUT == LOGIC_OUT)
    else $error("main output differs from logic output");
  ar_refused_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while data pending");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  write_answer_a: assert property (write_taken_s |=> !S_AXI_AWREADY && !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write answer wrong timing");
  gate_quiet_a: assert property (gate_shut_s |=> !SYNC_OUT && LOGIC_OUT == ctrl_reg[3])
    else $error("output active with gate closed");
endmodule
`default_nettype wire

// ### testbench/ppg_external_fire_position_src.sv
// Model of the external trigger or gate source and of the fire button
`default_nettype none
module ppg_external_fire_position_src (
  // Clock
  input wire logic CLK,
  // Pulse request
  input wire logic go,
  input wire logic [7:0] hi_len,
  // Driven line
  output var logic fire
);
  timeunit 1ns;
  timeprecision 1ns;
  // Line idles low so each rising edge is a fresh request; one process drives it
  initial
  begin
    fire = 1'b0;
    forever
    begin
      @(posedge CLK);
      if (go)
      begin
        fire <= 1'b1;
        repeat (hi_len) @(posedge CLK);
        fire <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/programmable_pulse_generator_tb_top.sv
// Self-checking bench for the programmable pulse generator
`default_nettype none
module programmable_pulse_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, go_f, go_m, fire, btn;
  logic awready, wready, bvalid, arready, rvalid, sync_o, logic_o, logic_n, main_o;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] len;
  int err_count, checked;
  ppg_top u_dut (
    .CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .FIRE_GATE_IN(fire), .MANUAL_FIRE_BUTTON(btn), .SYNC_OUT(sync_o),
    .LOGIC_OUT(logic_o), .LOGIC_OUT_N(logic_n), .MAIN_OUT(main_o)
  );
  ppg_external_fire_position_src u_src (.CLK(clk), .go(go_f), .hi_len(len), .fire(fire));
  ppg_external_fire_position_src u_btn (.CLK(clk), .go(go_m), .hi_len(len), .fire(btn));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hung(input int k);
    if (k >= 200)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      conclude();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw, w;
    int k;
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 200 && !(aw && w); k++)
    begin
      @(posedge clk);
      if (!aw && awready)
      begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready)
      begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    hung(k);
    bready <= 1'b1;
    for (k = 0; k < 200; k++)
    begin
      @(posedge clk);
      if (bvalid)
        break;
    end
    hung(k);
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 200; k++)
    begin
      @(posedge clk);
      if (arready)
        break;
    end
    hung(k);
    arvalid <= 1'b0;
    rready <= 1'b1;
    for (k = 0; k < 200; k++)
    begin
      @(posedge clk);
      if (rvalid)
        break;
    end
    hung(k);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic cfg(input logic [31:0] c, p, d, w);
    wr(ppg_pkg::ADDR_PERIOD, p, ppg_pkg::RESP_OKAY);
    wr(ppg_pkg::ADDR_DELAY, d, ppg_pkg::RESP_OKAY);
    wr(ppg_pkg::ADDR_WIDTH, w, ppg_pkg::RESP_OKAY);
    wr(ppg_pkg::ADDR_CTRL, c, ppg_pkg::RESP_OKAY);
    repeat (12) @(posedge clk);
  endtask
  // Eight cycles of outputs, taken from a sync rising edge onward
  task automatic pat(output logic [7:0] lo, output logic [7:0] sy);
    int k;
    for (k = 0; k < 200 && sync_o !== 1'b0; k++)
      @(posedge clk);
    hung(k);
    for (k = 0; k < 200 && sync_o !== 1'b1; k++)
      @(posedge clk);
    hung(k);
    for (k = 0; k < 8; k++)
    begin
      lo[k] = logic_o;
      sy[k] = sync_o;
      @(posedge clk);
    end
  endtask
  task automatic cnt(input int n, output int lo, output int sy);
    lo = 0;
    sy = 0;
    repeat (n)
    begin
      @(posedge clk);
      lo += logic_o;
      sy += sync_o;
    end
  endtask
  task automatic shot(input bit m, input logic [7:0] n, output int lo, output int sy);
    len <= n;
    go_m <= m;
    go_f <= !m;
    @(posedge clk);
    go_m <= 1'b0;
    go_f <= 1'b0;
    cnt(30, lo, sy);
  endtask
  task automatic lat(output int n);
    go_f <= 1'b1;
    @(posedge clk);
    go_f <= 1'b0;
    for (n = 0; n < 200 && sync_o !== 1'b1; n++)
      @(posedge clk);
    hung(n);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(ppg_pkg::ADDR_CTRL, d, r);
    chk(d, ppg_pkg::CTRL_RST);
    rd(ppg_pkg::ADDR_PERIOD, d, r);
    chk(d, ppg_pkg::PERIOD_RST);
    rd(ppg_pkg::ADDR_DELAY, d, r);
    chk(d, ppg_pkg::DELAY_RST);
    rd(ppg_pkg::ADDR_WIDTH, d, r);
    chk(d, ppg_pkg::WIDTH_RST);
    rd(5'h14, d, r);
    chk(d, 32'h0);
    chk(r, ppg_pkg::RESP_SLVERR);
    wr(5'h14, 32'h1, ppg_pkg::RESP_SLVERR);
    wr(ppg_pkg::ADDR_STATUS, 32'hF, ppg_pkg::RESP_OKAY);
    rd(ppg_pkg::ADDR_STATUS, d, r);
    chk(d & 32'h3, 32'h1);
    wr(ppg_pkg::ADDR_CTRL, 32'hFFFF_FFF0, ppg_pkg::RESP_OKAY);
    rd(ppg_pkg::ADDR_CTRL, d, r);
    chk(d, 32'h0);
  endtask
  task automatic t_cont();
    // Last case is a short period: width clamps to half, delay to the low fraction
    logic [31:0] tc [7] = '{32'h0, 32'h4, 32'h8, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] tp [7] = '{32'h8, 32'h8, 32'h8, 32'h8, 32'h8, 32'h0001_0001, 32'h3};
    logic [31:0] td [7] = '{32'h3, 32'h3, 32'h3, 32'h3, 32'h9, 32'h3, 32'h3};
    logic [31:0] tw [7] = '{32'h1, 32'h1, 32'h1, 32'h9, 32'h0006_0000, 32'h1, 32'h9};
    logic [7:0] el [7] = '{8'h08, 8'h09, 8'hF7, 8'hF8, 8'hE0, 8'h08, 8'h49};
    logic [7:0] es [7] = '{8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h1F, 8'h49};
    logic [7:0] lo, sy;
    for (int i = 0; i < 7; i++)
    begin
      cfg(tc[i], tp[i], td[i], tw[i]);
      pat(lo, sy);
      chk(lo, el[i]);
      chk(sy, es[i]);
    end
  endtask
  task automatic t_gate();
    int l1, l2, lo, sy;
    logic [7:0] pl, ps;
    cfg(32'h1, 32'h8, 32'h3, 32'h1);
    cnt(16, lo, sy);
    chk(lo + sy, 0);
    len <= 8'd40;
    lat(l1);
    pat(pl, ps);
    chk(pl, 8'h08);
    repeat (45) @(posedge clk);
    cnt(10, lo, sy);
    chk(lo + sy, 0);
    lat(l2);
    chk(l2, l1);
  endtask
  task automatic t_external_fire_position();
    int lo, sy;
    cfg(32'h2, 32'h8, 32'h3, 32'h1);
    cnt(16, lo, sy);
    chk(lo, 0);
    shot(0, 8'd2, lo, sy);
    chk(lo, 1);
    cfg(32'h6, 32'h8, 32'h3, 32'h1);
    shot(0, 8'd2, lo, sy);
    chk(lo, 2);
    cfg(32'h3, 32'h8, 32'h3, 32'h1);
    shot(1, 8'd2, lo, sy);
    chk(lo, 1);
    cfg(32'h2, 32'h8, 32'h3, 32'h0006_0000);
    shot(0, 8'd6, lo, sy);
    chk(lo, 6);
    chk(sy, 6);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    {rst, awvalid, wvalid, bready, arvalid, rready, go_f, go_m} = 8'hFF << 7;
    {awaddr, araddr, wdata, len} = '0;
    err_count = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_cont();
    t_gate();
    t_external_fire_position();
    conclude();
  end
endmodule
bind ppg_top ppg_asserts u_chk (
  .CLK(CLK), .SYS_RST(SYS_RST), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .FIRE_GATE_IN(FIRE_GATE_IN), .SYNC_OUT(SYNC_OUT), .LOGIC_OUT(LOGIC_OUT),
  .LOGIC_OUT_N(LOGIC_OUT_N), .MAIN_OUT(MAIN_OUT)
);
`default_nettype wire
